//--- pkg/ret_defines.svh
// constants for the reference encoder position tracker
`ifndef RET_DEFINES_SVH
`define RET_DEFINES_SVH

// register byte offsets
`define RET_OFS_CFG       12'h000
`define RET_OFS_LINES     12'h004
`define RET_OFS_GEAR_IN   12'h008
`define RET_OFS_GEAR_OUT  12'h00c
`define RET_OFS_TRIM      12'h010
`define RET_OFS_TALLY     12'h014
`define RET_OFS_TURNS     12'h018
`define RET_OFS_STATUS    12'h01c
`define RET_OFS_SPEED     12'h020
`define RET_OFS_SHAFT     12'h024
`define RET_OFS_LOAD      12'h028
`define RET_OFS_ABS       12'h02c

// cfg field positions
`define RET_CFG_KIND_LSB  0
`define RET_CFG_SWAP      4
`define RET_CFG_TCLR      5
`define RET_CFG_RETRY     6
`define RET_CFG_RUN       7

// reset values and limits
`define RET_LINES_RST     18'h00800
`define RET_GEAR_RST      32'h00000001
`define RET_LINES_MIN     18'h000fa
`define RET_LINES_MAX     18'h3ffff
`define RET_TRIM_MAX      32'h0036ee80

// encoder kind codes
`define RET_KIND_QUAD_SE  4'h0
`define RET_KIND_CD_SE    4'h1
`define RET_KIND_CLK_SE   4'h2
`define RET_KIND_QUAD_DF  4'h3
`define RET_KIND_CD_DF    4'h4
`define RET_KIND_CLK_DF   4'h5
`define RET_KIND_SINCOS   4'h6
`define RET_KIND_ABS_ST   4'h7
`define RET_KIND_ABS_MT   4'h8

// alignment state codes
`define RET_AL_NOT_REQ    4'h0
`define RET_AL_DRV_RUN    4'h1
`define RET_AL_MOT_RUN    4'h2
`define RET_AL_ENC_FLT    4'h3
`define RET_AL_IN_PROG    4'h4
`define RET_AL_ID_POS     4'h5
`define RET_AL_DONE       4'h6
`define RET_AL_LOST       4'h7
`define RET_AL_FAILED     4'h8

// timing: speed gate of 1 ms at a 50 ns clock
`define RET_GATE_NS       1000000
`define RET_CLK_NS        50
`define RET_ALIGN_TRIES   3'h4
`define RET_REV_BITS      12
`endif

//--- pkg/ret_pkg.sv
// types for the reference encoder position tracker
package ret_pkg;
    typedef struct packed {
        logic a;
        logic b;
    } ret_enc_s;

    typedef struct packed {
        logic valid;
        logic [17:0] rev_lsb;
        logic [11:0] rev_cnt;
        logic [31:0] angle;
    } ret_abs_s;

    typedef enum logic [5:0] {
        RET_IDLE = 6'b000001,
        RET_WAIT = 6'b000010,
        RET_ALIGN = 6'b000100,
        RET_IDPOS = 6'b001000,
        RET_DONE = 6'b010000,
        RET_FAIL = 6'b100000
    } ret_align_e;
endpackage

//--- hdl/ret_sync.sv
// two-flop synchroniser bank for encoder pins
`timescale 1ns/1ns
module ret_sync #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // meta is read only by dout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

//--- hdl/ret_decode.sv
// pulse decoder: quadrature, clock/direction and clock-only
`timescale 1ns/1ns
`include "ret_defines.svh"
module ret_decode
    import ret_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ret_enc_s enc,
    input wire logic [3:0] kind,
    input wire logic swap,
    output logic step,
    output logic up
);
    ret_enc_s prev;
    logic quad;
    logic cdir;
    logic raw_step;
    logic raw_up;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
        end else begin
            prev <= enc;
        end
    end

    assign quad = (kind == `RET_KIND_QUAD_SE) || (kind == `RET_KIND_QUAD_DF);
    assign cdir = (kind == `RET_KIND_CD_SE) || (kind == `RET_KIND_CD_DF);

    always_comb begin
        raw_step = 1'b0;
        raw_up = 1'b1;
        if (quad) begin
            // direction from combined phase states; a double jump is dropped
            raw_step = (prev.a ^ enc.a) ^ (prev.b ^ enc.b);
            raw_up = prev.a ^ enc.b;
        end else if (cdir) begin
            raw_step = prev.a ^ enc.a;
            raw_up = enc.b;
        end else if (kind == `RET_KIND_CLK_SE || kind == `RET_KIND_CLK_DF) begin
            raw_step = prev.a ^ enc.a;
            raw_up = 1'b1;
        end
    end

    assign step = raw_step;
    assign up = raw_up ^ swap;
endmodule

//--- hdl/ret_tracker.sv
// reference encoder position tracker with apb register file
`timescale 1ns/1ns
`include "ret_defines.svh"

// Operation
// - decode input by the encoder-kind selector codes.
// - flag an error when the kind does not match fitted hardware.
// - direction swap setting reverses the decoded direction.
// - lines per revolution accepted from 250 to 262143 for speed and turns.
// - edge tally advances on every encoder edge, four per line; the code counts A and B edges only in quadrature kinds, A edges in clock kinds.
// - edge tally is zero after reset and cleared while clear is set.
// - multi-turn absolute presets turn counter; low 12 bits track encoder.
// - absolute kinds align absolute data with incremental feedback at power-up.
// - alignment state codes 0 to 8 as listed; the code never reports code 3, encoder fault.
// - non-absolute kinds report the not-required alignment code.
// - failed alignment signals an error when the drive is started.
// - after several failed tries enter failed; restart on retry or setting change.
// - retry setting returns to false once alignment finishes.
// - load position derives from shaft position through the gear ratio.
// - load equals shaft at power-up, retained with multi-turn absolute.
// - absolute kinds subtract a zero-angle trim of 0 to 360 degrees.
// - present mechanical speed in revolutions per minute.
// - quadrature direction from combined states of channels A and B.
// - speed in hertz is edges per second over four times lines.
module ret_tracker
    import ret_pkg::*;
#(
    parameter int GATE_CYC = `RET_GATE_NS / `RET_CLK_NS,
    parameter logic [15:0] HW_KINDS = 16'h003f
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ret_enc_s enc_pin,
    input wire logic motor_stopped,
    input wire ret_abs_s abs_in,
    output logic kind_error,
    output logic start_error
);
    // ***************************************************************
    // registers
    // ***************************************************************
    logic [3:0] kind;
    logic swap;
    logic tally_clr;
    logic retry;
    logic run;
    logic [17:0] lines;
    logic [31:0] gear_input_turns;
    logic [31:0] gear_output_turns;
    logic [31:0] zero_angle_trim;
    logic [31:0] edge_tally;
    logic [31:0] turns;
    logic [19:0] line_pos;
    logic [31:0] speed_rpm;
    logic [31:0] shaft_pos;
    logic [31:0] load_pos;
    logic [3:0] abs_align_state;
    ret_align_e st;
    logic [2:0] tries;
    logic wr;
    logic rd;
    logic cfg_change;
    logic is_abs;
    ret_enc_s enc_s;
    logic step;
    logic up;
    ret_abs_s abs_s;
    ret_abs_s abs_m;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign is_abs = (kind == `RET_KIND_ABS_ST) || (kind == `RET_KIND_ABS_MT);
    assign cfg_change = wr && (paddr == `RET_OFS_CFG)
        && (pwdata[`RET_CFG_KIND_LSB +: 4] != kind);

    ret_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(enc_pin),
        .dout(enc_s)
    );

    ret_decode u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .enc(enc_s),
        .kind(kind),
        .swap(swap),
        .step(step),
        .up(up)
    );

    // absolute data runs on the encoder's own timing; two stages like the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abs_m <= '0;
            abs_s <= '0;
        end else begin
            abs_m <= abs_in;
            abs_s <= abs_m;
        end
    end

    // ***************************************************************
    // configuration writes
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind <= `RET_KIND_QUAD_SE;
            swap <= 1'b0;
            tally_clr <= 1'b0;
            run <= 1'b0;
            lines <= `RET_LINES_RST;
            gear_input_turns <= `RET_GEAR_RST;
            gear_output_turns <= `RET_GEAR_RST;
            zero_angle_trim <= '0;
        end else if (wr) begin
            case (paddr)
                `RET_OFS_CFG: begin
                    kind <= pwdata[`RET_CFG_KIND_LSB +: 4];
                    swap <= pwdata[`RET_CFG_SWAP];
                    tally_clr <= pwdata[`RET_CFG_TCLR];
                    run <= pwdata[`RET_CFG_RUN];
                end
                `RET_OFS_LINES: begin
                    // out-of-range values are clamped to the legal span
                    if (pwdata[17:0] < `RET_LINES_MIN || pwdata[31:18] != '0) begin
                        lines <= (pwdata[31:18] != '0) ? `RET_LINES_MAX : `RET_LINES_MIN;
                    end else begin
                        lines <= pwdata[17:0];
                    end
                end
                `RET_OFS_GEAR_IN: begin
                    gear_input_turns <= (pwdata == '0) ? `RET_GEAR_RST : pwdata;
                end
                `RET_OFS_GEAR_OUT: gear_output_turns <= pwdata;
                `RET_OFS_TRIM: begin
                    if (pwdata <= `RET_TRIM_MAX) begin
                        zero_angle_trim <= pwdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // retry is self-clearing once alignment finishes; a write setting retry wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry <= 1'b0;
        end else if (wr && paddr == `RET_OFS_CFG && pwdata[`RET_CFG_RETRY]) begin
            retry <= 1'b1;
        end else if (st == RET_DONE) begin
            retry <= 1'b0;
        end
    end

    // ***************************************************************
    // tally, line position and turns
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_tally <= '0;
        end else if (tally_clr) begin
            edge_tally <= '0;
        end else if (step) begin
            edge_tally <= edge_tally + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_pos <= '0;
            turns <= '0;
        end else if (kind == `RET_KIND_ABS_MT && abs_s.valid && st == RET_IDPOS) begin
            // keep the upper bits, match the low bits to the encoder revs
            line_pos <= {2'h0, abs_s.rev_lsb};
            turns <= {turns[31:`RET_REV_BITS], abs_s.rev_cnt};
        end else if (step && up) begin
            if (line_pos >= {lines, 2'h0} - 20'h1) begin
                line_pos <= '0;
                turns <= turns + 32'h1;
            end else begin
                line_pos <= line_pos + 20'h1;
            end
        end else if (step) begin
            if (line_pos == '0) begin
                line_pos <= {lines, 2'h0} - 20'h1;
                turns <= turns - 32'h1;
            end else begin
                line_pos <= line_pos - 20'h1;
            end
        end
    end

    // ***************************************************************
    // speed: edges per gate, scaled to rpm
    // ***************************************************************
    logic [31:0] gate_cnt;
    logic [31:0] gate_edges;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_cnt <= '0;
            gate_edges <= '0;
            speed_rpm <= '0;
        end else if (gate_cnt == 32'(GATE_CYC - 1)) begin
            gate_cnt <= '0;
            gate_edges <= !step ? 32'h0 : up ? 32'h1 : 32'hffffffff;
            // rpm = edges/s * 60 / (4*lines); divide kept simple at gate rate
            speed_rpm <= 32'((64'($signed(gate_edges)) * 64'sd60 * 64'sd1000000000
                / 64'(GATE_CYC * `RET_CLK_NS)) / $signed(64'({lines, 2'h0})));
        end else begin
            gate_cnt <= gate_cnt + 32'h1;
            if (step) begin
                gate_edges <= up ? gate_edges + 32'h1 : gate_edges - 32'h1;
            end
        end
    end

    // ***************************************************************
    // shaft and load positions
    // ***************************************************************
    logic [31:0] shaft_raw;
    assign shaft_raw = is_abs && st == RET_DONE ? abs_s.angle : {12'h0, line_pos};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shaft_pos <= '0;
            load_pos <= '0;
        end else begin
            shaft_pos <= is_abs ? shaft_raw - zero_angle_trim : shaft_raw;
            // multi-turn keeps load after alignment through absolute turns
            load_pos <= 32'(($signed({32'h0, shaft_pos}) + 64'($signed(turns))
                * $signed(64'({lines, 2'h0}))) * 64'($signed(gear_output_turns))
                / $signed({32'h0, gear_input_turns}));
        end
    end

    // ***************************************************************
    // absolute alignment state machine
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RET_IDLE;
            tries <= '0;
        end else if (!is_abs) begin
            st <= RET_IDLE;
            tries <= '0;
        end else begin
            case (st)
                RET_IDLE: st <= RET_WAIT;
                RET_WAIT: begin
                    if (!run && motor_stopped) begin
                        st <= RET_ALIGN;
                    end
                end
                RET_ALIGN: begin
                    if (abs_s.valid) begin
                        st <= RET_IDPOS;
                    end else if (tries == `RET_ALIGN_TRIES) begin
                        st <= RET_FAIL;
                    end else begin
                        tries <= tries + 3'h1;
                    end
                end
                RET_IDPOS: st <= RET_DONE;
                RET_DONE: begin
                    if (cfg_change) begin
                        st <= RET_IDLE;
                        tries <= '0;
                    end
                end
                RET_FAIL: begin
                    if (retry || cfg_change) begin
                        st <= RET_IDLE;
                        tries <= '0;
                    end
                end
                default: st <= RET_IDLE;
            endcase
        end
    end

    always_comb begin
        abs_align_state = `RET_AL_NOT_REQ;
        if (is_abs) begin
            case (st)
                RET_WAIT: abs_align_state = run ? `RET_AL_DRV_RUN : `RET_AL_MOT_RUN;
                RET_ALIGN: abs_align_state = `RET_AL_IN_PROG;
                RET_IDPOS: abs_align_state = `RET_AL_ID_POS;
                RET_DONE: abs_align_state = abs_s.valid ? `RET_AL_DONE : `RET_AL_LOST;
                RET_FAIL: abs_align_state = `RET_AL_FAILED;
                default: abs_align_state = `RET_AL_IN_PROG;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_error <= 1'b0;
            start_error <= 1'b0;
        end else begin
            kind_error <= (kind > `RET_KIND_ABS_MT) || !HW_KINDS[kind];
            start_error <= run && is_abs && st != RET_DONE;
        end
    end

    // ***************************************************************
    // read mux
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `RET_OFS_CFG: prdata <= {24'h0, run, retry, tally_clr, swap, kind};
                `RET_OFS_LINES: prdata <= {14'h0, lines};
                `RET_OFS_GEAR_IN: prdata <= gear_input_turns;
                `RET_OFS_GEAR_OUT: prdata <= gear_output_turns;
                `RET_OFS_TRIM: prdata <= zero_angle_trim;
                `RET_OFS_TALLY: prdata <= edge_tally;
                `RET_OFS_TURNS: prdata <= turns;
                `RET_OFS_STATUS: prdata <= {26'h0, kind_error, start_error, abs_align_state};
                `RET_OFS_SPEED: prdata <= speed_rpm;
                `RET_OFS_SHAFT: prdata <= shaft_pos;
                `RET_OFS_LOAD: prdata <= load_pos;
                default: prdata <= '0;
            endcase
        end
    end

    assign pslverr = (rd || wr) && (paddr > `RET_OFS_LOAD || paddr[1:0] != 2'h0);

    // ***************************************************************
    // checks
    // ***************************************************************
    AST_TALLY_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        tally_clr |=> edge_tally == '0) else $error("tally not cleared");
    AST_TALLY_INC: assert property (@(posedge pclk) disable iff (!presetn)
        step && !tally_clr |=> edge_tally == $past(edge_tally) + 32'h1)
        else $error("tally missed an edge");
    AST_NOT_REQ: assert property (@(posedge pclk) disable iff (!presetn)
        !is_abs |-> abs_align_state == 4'h0) else $error("align code wrong");
    AST_FAIL_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        is_abs && st == RET_FAIL |-> abs_align_state == 4'h8) else $error("fail code");
    AST_RETRY_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        st == RET_DONE && !wr |=> !retry) else $error("retry stuck");
    AST_FAIL_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        is_abs && st == RET_FAIL && retry |=> st == RET_IDLE)
        else $error("no restart");
    AST_START_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        run && is_abs && st == RET_FAIL |=> start_error) else $error("no start error");
    AST_KIND_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        kind > 4'h8 |=> kind_error) else $error("kind error missing");
    AST_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
        step && !swap && kind == 4'h2 |-> up) else $error("clock-only direction");
    COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) st == RET_DONE);
    COV_FAIL: cover property (@(posedge pclk) disable iff (!presetn) st == RET_FAIL);
    COV_TURN: cover property (@(posedge pclk) disable iff (!presetn) step ##1 turns != '0);
endmodule

//--- testbench/ret_enc_model.sv
// encoder model: quadrature pulse source and absolute data source
`timescale 1ns/1ns
module ret_enc_model
    import ret_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic rev,
    input wire logic [15:0] steps,
    input wire logic abs_ok,
    input wire logic [11:0] rev_cnt,
    output ret_enc_s enc,
    output ret_abs_s abs_out,
    output logic busy
);
    logic [15:0] left;
    logic [1:0] ph;
    logic [1:0] div;
    assign busy = (left != 16'h0000);
    // gray sequence keeps a and b a quarter cycle apart
    assign enc = '{a: ph[1], b: ph[1] ^ ph[0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 16'h0000;
            ph <= 2'h0;
            div <= 2'h0;
        end else if (go) begin
            left <= steps;
        end else if (busy) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                ph <= rev ? ph - 2'h1 : ph + 2'h1;
                left <= left - 16'h0001;
            end
        end
    end
    // invalid frames carry a toggling pattern so stale data cannot pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abs_out <= '0;
        end else begin
            abs_out.valid <= abs_ok;
            abs_out.rev_cnt <= abs_ok ? rev_cnt : ~abs_out.rev_cnt;
            abs_out.rev_lsb <= abs_ok ? 18'h00000 : ~abs_out.rev_lsb;
            abs_out.angle <= abs_ok ? 32'h00000000 : ~abs_out.angle;
        end
    end
endmodule

//--- testbench/ret_tracker_tb_top.sv
// testbench for the reference encoder position tracker
`timescale 1ns/1ns
`include "ret_defines.svh"
module ret_tracker_tb_top
    import ret_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic go = 1'b0;
    logic rev = 1'b0;
    logic [15:0] steps = 16'h0000;
    logic abs_ok = 1'b0;
    logic motor_stopped = 1'b1;
    logic [11:0] rev_cnt = 12'h123;
    ret_enc_s enc;
    ret_abs_s abs_data;
    logic busy;
    logic kind_error;
    logic start_error;
    logic [31:0] q;
    logic e;
    int failures = 0;
    int n_tests = 0;
    int k;

    ret_tracker #(.GATE_CYC(20), .HW_KINDS(16'h01ff)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_pin(enc),
        .motor_stopped(motor_stopped), .abs_in(abs_data), .kind_error(kind_error),
        .start_error(start_error));
    ret_enc_model PEER (.pclk(pclk), .presetn(presetn), .go(go), .rev(rev), .steps(steps),
        .abs_ok(abs_ok), .rev_cnt(rev_cnt), .enc(enc), .abs_out(abs_data), .busy(busy));

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // pready is sampled with the access phase; an idle cycle follows each transfer
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        cmp(q & m, exp);
    endtask
    task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, a, 32'h00000000);
            if ((q & m) === exp) break;
        end
        cmp(q & m, exp);
    endtask
    // the sync and decode pipeline needs a few clocks after the last pin change
    task move(input logic [15:0] n, input logic r);
        int i;
        steps <= n;
        rev <= r;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (i = 0; i < 10000; i++) begin
            @(posedge pclk);
            if (busy === 1'b0) break;
        end
        if (i == 10000) begin
            failures++;
            wrap_up();
        end
        repeat (8) @(posedge pclk);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(`RET_OFS_LINES, 32'hffffffff, 32'h00000800);
        chk(`RET_OFS_GEAR_IN, 32'hffffffff, 32'h00000001);
        chk(`RET_OFS_TALLY, 32'hffffffff, 32'h00000000);
        chk(`RET_OFS_TURNS, 32'hffffffff, 32'h00000000);
        chk(`RET_OFS_STATUS, 32'hffffffff, 32'h00000000);
        apb(1'b0, 12'h030, 32'h00000000);
        cmp(q, 32'h00000000);
        cmp({31'h0, e}, 32'h00000001);
        apb(1'b1, `RET_OFS_LINES, 32'h00000064);
        chk(`RET_OFS_LINES, 32'hffffffff, 32'h000000fa);
        apb(1'b1, `RET_OFS_LINES, 32'h0003ffff);
        chk(`RET_OFS_LINES, 32'hffffffff, 32'h0003ffff);
        apb(1'b1, `RET_OFS_LINES, 32'h000000fa);
        apb(1'b1, `RET_OFS_GEAR_IN, 32'h00000000);
        chk(`RET_OFS_GEAR_IN, 32'hffffffff, 32'h00000001);
        apb(1'b1, `RET_OFS_TRIM, 32'h0036ee81);
        chk(`RET_OFS_TRIM, 32'hffffffff, 32'h00000000);
        apb(1'b1, `RET_OFS_TRIM, 32'h0036ee80);
        chk(`RET_OFS_TRIM, 32'hffffffff, 32'h0036ee80);
        // 1002 edges at 250 lines is one whole turn plus two edges
        apb(1'b1, `RET_OFS_CFG, 32'h00000000);
        move(16'd1002, 1'b0);
        apb(1'b0, `RET_OFS_TALLY, 32'h00000000);
        cmp(q[31] ? -q : q, 32'd1002);
        apb(1'b0, `RET_OFS_TURNS, 32'h00000000);
        cmp(q[31] ? -q : q, 32'd1);
        chk(`RET_OFS_LOAD, 32'hffffffff, 32'd1002);
        apb(1'b1, `RET_OFS_CFG, 32'h00000010);
        move(16'd1002, 1'b0);
        chk(`RET_OFS_TURNS, 32'hffffffff, 32'h00000000);
        apb(1'b1, `RET_OFS_CFG, 32'h00000020);
        chk(`RET_OFS_TALLY, 32'hffffffff, 32'h00000000);
        for (k = 0; k < 7; k++) begin
            apb(1'b1, `RET_OFS_CFG, k);
            chk(`RET_OFS_STATUS, 32'h0000003f, 32'h00000000);
        end
        // clock-only counts each edge of the first pin: eight quadrature steps give four
        apb(1'b1, `RET_OFS_CFG, 32'h00000002);
        move(16'd8, 1'b0);
        chk(`RET_OFS_TALLY, 32'hffffffff, 32'h00000004);
        apb(1'b1, `RET_OFS_CFG, 32'h00000009);
        repeat (2) @(posedge pclk);
        cmp({31'h0, kind_error}, 32'h00000001);
        apb(1'b1, `RET_OFS_CFG, 32'h00000007);
        poll(`RET_OFS_STATUS, 32'h0000000f, 32'h00000008);
        apb(1'b1, `RET_OFS_CFG, 32'h00000087);
        repeat (2) @(posedge pclk);
        cmp({31'h0, start_error}, 32'h00000001);
        abs_ok <= 1'b1;
        apb(1'b1, `RET_OFS_CFG, 32'h00000047);
        poll(`RET_OFS_STATUS, 32'h0000000f, 32'h00000006);
        chk(`RET_OFS_CFG, 32'h00000040, 32'h00000000);
        abs_ok <= 1'b0;
        poll(`RET_OFS_STATUS, 32'h0000000f, 32'h00000007);
        abs_ok <= 1'b1;
        apb(1'b1, `RET_OFS_CFG, 32'h00000008);
        poll(`RET_OFS_STATUS, 32'h0000000f, 32'h00000006);
        chk(`RET_OFS_TURNS, 32'h00000fff, 32'h00000123);
        motor_stopped <= 1'b0;
        apb(1'b1, `RET_OFS_CFG, 32'h00000047);
        poll(`RET_OFS_STATUS, 32'h0000000f, 32'h00000002);
        wrap_up();
    end
endmodule
